// [rtl/general_purpose_port_block.sv]
// general-purpose port block: two programmable 4-bit ports, five fixed ports
// assumes a cpu-side register port with one-cycle strobes and pins on the other side
// Functional notes
// - programmable port one drives all four pins when direction bit 0 is set.
// - programmable port two drives all four pins when direction bit 1 is set.
// - an output programmable port drives its last written latch value.
// - input port reads return pin levels, not the latch.
// - data registers accept writes and reads in either direction.
// - reset clears both direction bits, so both ports start as inputs.
// - 2-bit port c has build-time per-bit direction.
// - 4-bit port d has build-time per-bit direction.
// - 4-bit port e has build-time per-bit direction.
// - 3-bit port f has build-time per-bit direction.
// - 2-bit port g has build-time per-bit direction.
// - a build-time switch removes port g entirely.
// - a build-time switch gives port one pins to analog channels four to seven.
// - every port line maps to a register bit.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "gpio_port_defs.svh"
`timescale 1ns/1ps
module general_purpose_port_block #(
    parameter logic [1:0] DIR_C = 2'h0,
    parameter logic [3:0] DIR_D = 4'h0,
    parameter logic [3:0] DIR_E = 4'h0,
    parameter logic [2:0] DIR_F = 3'h0,
    parameter logic [1:0] DIR_G = 2'h0,
    parameter bit HAS_PORT_G = 1'b1,
    parameter bit PORT_ONE_ANALOG = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [3:0] reg_rdata,
    input wire logic [3:0] one_in,
    output logic [3:0] one_out,
    output logic [3:0] one_oe,
    input wire logic [3:0] two_in,
    output logic [3:0] two_out,
    output logic [3:0] two_oe,
    input wire logic [1:0] c_in,
    output logic [1:0] c_out,
    output logic [1:0] c_oe,
    input wire logic [3:0] d_in,
    output logic [3:0] d_out,
    output logic [3:0] d_oe,
    input wire logic [3:0] e_in,
    output logic [3:0] e_out,
    output logic [3:0] e_oe,
    input wire logic [2:0] f_in,
    output logic [2:0] f_out,
    output logic [2:0] f_oe,
    input wire logic [1:0] g_in,
    output logic [1:0] g_out,
    output logic [1:0] g_oe,
    output logic analog_select
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic table_sel_ff;
    logic [1:0] dir_ff;
    gpio_port_pkg::nibble_t one_lat_ff, two_lat_ff, d_lat_ff, e_lat_ff;
    logic [1:0] c_lat_ff, g_lat_ff;
    logic [2:0] f_lat_ff;
    logic [3:0] one_oe_ff, two_oe_ff;
    logic [3:0] rdata_ff;
    logic analog_ff;
    logic [20:0] pins_raw, pins_sync;

    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    assign pins_raw = {f_in, e_in, d_in, c_in, two_in, one_in};

    pin_sync #(.WIDTH(21)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(pins_raw),
        .pin_sync_out(pins_sync)
    );

    wire [3:0] one_s = pins_sync[3:0];
    wire [3:0] two_s = pins_sync[7:4];
    wire [1:0] c_s = pins_sync[9:8];
    wire [3:0] d_s = pins_sync[13:10];
    wire [3:0] e_s = pins_sync[17:14];
    wire [2:0] f_s = pins_sync[20:18];
    // port g keeps its own two stages, so the shared bus stops at port f
    logic [1:0] g_meta_ff;
    logic [1:0] g_s_ff;

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    // mix a latch with live pins: output bits read the latch, inputs the pin
    function automatic logic [3:0] mix(input logic [3:0] dir, input logic [3:0] lat,
                                       input logic [3:0] pin);
        mix = (dir & lat) | (~dir & pin);
    endfunction : mix

    wire hit_ports = table_sel_ff;
    wire wr_sel = reg_wr && (reg_addr == `OFS_TABLE_SELECT);
    wire wr_one = reg_wr && hit_ports && (reg_addr == `OFS_PROG_ONE);
    wire wr_two = reg_wr && hit_ports && (reg_addr == `OFS_PROG_TWO);
    wire wr_c = reg_wr && hit_ports && (reg_addr == `OFS_FIXED_C);
    wire wr_d = reg_wr && hit_ports && (reg_addr == `OFS_FIXED_D);
    wire wr_e = reg_wr && hit_ports && (reg_addr == `OFS_FIXED_E);
    wire wr_f = reg_wr && hit_ports && (reg_addr == `OFS_FIXED_F);
    wire wr_g = reg_wr && hit_ports && (reg_addr == `OFS_FIXED_G) && HAS_PORT_G;
    wire wr_dir = reg_wr && hit_ports && (reg_addr == `OFS_DIR_CTRL);

    // per-pin enables of the programmable ports, whole nibble at once
    wire one_drive = dir_ff[`DIR_ONE_BIT] && !PORT_ONE_ANALOG;
    wire two_drive = dir_ff[`DIR_TWO_BIT];
    wire [3:0] nxt_one_oe = {4{one_drive}};
    wire [3:0] nxt_two_oe = {4{two_drive}};

    // read mux; programmable ports read pins when input, latch when output
    wire [3:0] rd_one = PORT_ONE_ANALOG ? 4'h0 : mix(nxt_one_oe, one_lat_ff, one_s);
    wire [3:0] rd_two = mix(nxt_two_oe, two_lat_ff, two_s);
    wire [3:0] rd_c = mix({2'h0, DIR_C}, {2'h0, c_lat_ff}, {2'h0, c_s});
    wire [3:0] rd_d = mix(DIR_D, d_lat_ff, d_s);
    wire [3:0] rd_e = mix(DIR_E, e_lat_ff, e_s);
    wire [3:0] rd_f = mix({1'b0, DIR_F}, {1'b0, f_lat_ff}, {1'b0, f_s});
    wire [3:0] rd_g = HAS_PORT_G ? mix({2'h0, DIR_G}, {2'h0, g_lat_ff}, {2'h0, g_s_ff})
                                 : 4'h0;
    logic [3:0] nxt_rdata;

    // table select reads in both tables; others only in the second
    always_comb begin
        nxt_rdata = 4'h0;
        if (reg_addr == `OFS_TABLE_SELECT) begin
            nxt_rdata = {3'h0, table_sel_ff};
        end else if (hit_ports) begin
            case (reg_addr)
                `OFS_PROG_ONE: nxt_rdata = rd_one;
                `OFS_PROG_TWO: nxt_rdata = rd_two;
                `OFS_FIXED_C: nxt_rdata = rd_c;
                `OFS_FIXED_D: nxt_rdata = rd_d;
                `OFS_FIXED_E: nxt_rdata = rd_e;
                `OFS_FIXED_F: nxt_rdata = rd_f;
                `OFS_FIXED_G: nxt_rdata = rd_g;
                `OFS_DIR_CTRL: nxt_rdata = {2'h0, dir_ff};
                default: nxt_rdata = 4'h0;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // control registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            table_sel_ff <= `TABLE_RESET;
            dir_ff <= `DIR_RESET;
        end else begin
            if (wr_sel) table_sel_ff <= reg_wdata[`TABLE_SEL_BIT];
            if (wr_dir) dir_ff <= reg_wdata[1:0];
        end
    end

    // output latches written regardless of direction
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            one_lat_ff <= `LATCH_RESET;
            two_lat_ff <= `LATCH_RESET;
            d_lat_ff <= `LATCH_RESET;
            e_lat_ff <= `LATCH_RESET;
        end else begin
            if (wr_one) one_lat_ff <= reg_wdata;
            if (wr_two) two_lat_ff <= reg_wdata;
            if (wr_d) d_lat_ff <= reg_wdata;
            if (wr_e) e_lat_ff <= reg_wdata;
        end
    end

    // narrow latches of the fixed ports
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            c_lat_ff <= 2'h0;
            f_lat_ff <= 3'h0;
            g_lat_ff <= 2'h0;
        end else begin
            if (wr_c) c_lat_ff <= reg_wdata[1:0];
            if (wr_f) f_lat_ff <= reg_wdata[2:0];
            if (wr_g) g_lat_ff <= reg_wdata[1:0];
        end
    end

    // port g synchroniser kept local; stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            g_meta_ff <= 2'h0;
            g_s_ff <= 2'h0;
        end else begin
            g_meta_ff <= g_in;
            g_s_ff <= g_meta_ff;
        end
    end

    // registered enables and read data
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            one_oe_ff <= 4'h0;
            two_oe_ff <= 4'h0;
            rdata_ff <= 4'h0;
            analog_ff <= 1'b0;
        end else begin
            one_oe_ff <= nxt_one_oe;
            two_oe_ff <= nxt_two_oe;
            rdata_ff <= reg_rd ? nxt_rdata : 4'h0;
            analog_ff <= PORT_ONE_ANALOG;
        end
    end

    // -----------------------------------------------------------------
    // pin outputs from flip-flops; fixed-port enables come straight from the build-time masks
    // -----------------------------------------------------------------
    assign reg_rdata = rdata_ff;
    assign one_out = PORT_ONE_ANALOG ? 4'h0 : one_lat_ff;
    assign one_oe = one_oe_ff;
    assign two_out = two_lat_ff;
    assign two_oe = two_oe_ff;
    assign c_out = c_lat_ff & DIR_C;
    assign c_oe = DIR_C;
    assign d_out = d_lat_ff & DIR_D;
    assign d_oe = DIR_D;
    assign e_out = e_lat_ff & DIR_E;
    assign e_oe = DIR_E;
    assign f_out = f_lat_ff & DIR_F;
    assign f_oe = DIR_F;
    assign g_out = HAS_PORT_G ? (g_lat_ff & DIR_G) : 2'h0;
    assign g_oe = HAS_PORT_G ? DIR_G : 2'h0;
    assign analog_select = analog_ff;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    dir_reset_a: assert property (@(posedge clk) !reset_n |=> dir_ff == 2'h0)
        else $error("direction not cleared by reset");
    one_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        (dir_ff[0] && !PORT_ONE_ANALOG) |=> one_oe == 4'hf)
        else $error("port one not driving");
    two_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        !dir_ff[1] |=> two_oe == 4'h0)
        else $error("port two driving while input");
    latch_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_two |=> two_out == $past(reg_wdata))
        else $error("port two latch not updated");
    latch_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!wr_one && !PORT_ONE_ANALOG) |=> one_out == $past(one_out))
        else $error("port one latch changed without write");
    pin_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && hit_ports && reg_addr == `OFS_PROG_TWO && !two_drive)
        |=> reg_rdata == $past(two_s))
        else $error("port two input read wrong");
    table_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_wr && !table_sel_ff) |=> $stable(dir_ff))
        else $error("write landed with first table selected");
    // the release edge starts no attempt: the stages were still cleared by reset there
    sync_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        reset_n |-> ##2 one_s == $past(one_in, 2))
        else $error("synchroniser depth wrong");
    f_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
        reset_n |-> ##2 f_s == $past(f_in, 2))
        else $error("port f synchroniser wrong");
    g_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
        reset_n |-> ##2 g_s_ff == $past(g_in, 2))
        else $error("port g synchroniser wrong");
    // direction bits and the enables that follow them one cycle later
    dir_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_dir |=> dir_ff == $past(reg_wdata[1:0]))
        else $error("direction write lost");
    one_input_a: assert property (@(posedge clk) disable iff (!reset_n)
        !one_drive |=> one_oe == 4'h0)
        else $error("port one driving while input");
    two_output_a: assert property (@(posedge clk) disable iff (!reset_n)
        dir_ff[1] |=> two_oe == 4'hf)
        else $error("port two not driving");
    select_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_sel |=> table_sel_ff == $past(reg_wdata[0]))
        else $error("table select write lost");

    // -----------------------------------------------------------------
    // checks: latches and pins
    // -----------------------------------------------------------------
    reset_outputs_a: assert property (@(posedge clk)
        !reset_n |=> one_oe == 4'h0 && two_oe == 4'h0 && two_out == 4'h0)
        else $error("outputs not cleared by reset");
    one_latch_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_one && !PORT_ONE_ANALOG) |=> one_out == $past(reg_wdata))
        else $error("port one pins not updated");
    input_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_one && !one_drive) |=> one_lat_ff == $past(reg_wdata))
        else $error("latch write lost while input");
    // fixed ports show written bits only where the mask marks an output
    fixed_c_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_c |=> c_out == ($past(reg_wdata[1:0]) & DIR_C))
        else $error("port c output wrong");
    fixed_d_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_d |=> d_out == ($past(reg_wdata) & DIR_D))
        else $error("port d output wrong");
    fixed_e_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_e |=> e_out == ($past(reg_wdata) & DIR_E))
        else $error("port e output wrong");
    fixed_f_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_f |=> f_out == ($past(reg_wdata[2:0]) & DIR_F))
        else $error("port f output wrong");
    fixed_g_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_g |=> g_out == ($past(reg_wdata[1:0]) & DIR_G))
        else $error("port g output wrong");

    // -----------------------------------------------------------------
    // checks: read path
    // -----------------------------------------------------------------
    // read data stand one cycle after the strobe and are zero otherwise
    one_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && hit_ports && reg_addr == `OFS_PROG_ONE && !one_drive && !PORT_ONE_ANALOG)
        |=> reg_rdata == $past(one_s))
        else $error("port one input read wrong");
    g_absent_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!HAS_PORT_G && reg_rd && reg_addr == `OFS_FIXED_G)
        |=> reg_rdata == 4'h0)
        else $error("absent port g read nonzero");
    analog_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (PORT_ONE_ANALOG && reg_rd && reg_addr == `OFS_PROG_ONE)
        |=> reg_rdata == 4'h0)
        else $error("analog port one read nonzero");
    unmapped_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_rd && reg_addr > `OFS_FIXED_G && reg_addr != `OFS_DIR_CTRL)
        |=> reg_rdata == 4'h0)
        else $error("unmapped index read nonzero");
    idle_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        !reg_rd |=> reg_rdata == 4'h0)
        else $error("read data without strobe");
endmodule : general_purpose_port_block

// [rtl/gpio_port_defs.svh]
// register offsets, reset values and field positions of the port block
// assumes inclusion by bare name from the design files
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// -----------------------------------------------------------------
// register offsets (second peripheral table, index on 4-bit address)
// -----------------------------------------------------------------
`define OFS_TABLE_SELECT 4'h0
`define OFS_PROG_ONE 4'h1
`define OFS_PROG_TWO 4'h2
`define OFS_FIXED_C 4'h3
`define OFS_FIXED_D 4'h4
`define OFS_FIXED_E 4'h5
`define OFS_FIXED_F 4'h6
`define OFS_FIXED_G 4'h7
`define OFS_DIR_CTRL 4'hd

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define DIR_ONE_BIT 0
`define DIR_TWO_BIT 1
`define TABLE_SEL_BIT 0
`define DIR_RESET 2'h0
`define TABLE_RESET 1'h0
`define LATCH_RESET 4'h0

`endif

// [rtl/gpio_port_pkg.sv]
// types shared by the port block files
// assumes nothing beyond a SystemVerilog compiler
package gpio_port_pkg;
    typedef logic [3:0] nibble_t;
    typedef enum logic [0:0] {
        DIR_INPUT = 1'b0,
        DIR_OUTPUT = 1'b1
    } port_dir_t;
endpackage : gpio_port_pkg

// [rtl/pin_sync.sv]
// two-stage synchroniser for a group of input pins
// assumes a single system clock and a synchronous active-low reset
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync_out = sync_ff;
endmodule : pin_sync

// [verification/pin_partner.sv]
// external circuitry on one port: drives whichever lines the block leaves free
// assumes out and oe come from the block and ext from the bench
`timescale 1ns/1ps
module pin_partner #(
    parameter int W = 4
) (
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    output logic [W-1:0] pin
);
    // a driven line shows the block's level, a released one the circuit's own
    assign pin = (oe & out) | (~oe & ext);
endmodule : pin_partner

// [verification/tb.sv]
// self-checking bench: port block against a register-level model
// assumes pin_partner beside each port; second instance drops port g, gives port one away
`timescale 1ns/1ps
module tb;
    localparam logic [1:0] MC = 2'h1;
    localparam logic [3:0] MD = 4'ha;
    localparam logic [3:0] ME = 4'h5;
    localparam logic [2:0] MF = 3'h6;
    localparam logic [1:0] MG = 2'h2;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] reg_wdata = 4'h0;
    logic [3:0] rdata, rdata2, one_out, one_oe, two_out, two_oe, d_out, d_oe, e_out, e_oe;
    logic [3:0] one_pin, two_pin, d_pin, e_pin, one_oe2;
    logic [1:0] c_out, c_oe, g_out, g_oe, c_pin, g_pin;
    logic [2:0] f_out, f_oe, f_pin;
    logic analog1, analog2;
    logic [3:0] xv [1:7];
    int lat [16];
    int sel = 0;
    int dir = 0;
    int n_fail = 0;
    int total_checks = 0;

    // ---------------------------------------------------------------
    // design instances and the circuitry around them
    // ---------------------------------------------------------------
    general_purpose_port_block #(.DIR_C(MC), .DIR_D(MD), .DIR_E(ME), .DIR_F(MF),
        .DIR_G(MG)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .one_in(one_pin), .one_out(one_out), .one_oe(one_oe), .two_in(two_pin),
        .two_out(two_out), .two_oe(two_oe), .c_in(c_pin), .c_out(c_out), .c_oe(c_oe),
        .d_in(d_pin), .d_out(d_out), .d_oe(d_oe), .e_in(e_pin), .e_out(e_out),
        .e_oe(e_oe), .f_in(f_pin), .f_out(f_out), .f_oe(f_oe), .g_in(g_pin),
        .g_out(g_out), .g_oe(g_oe), .analog_select(analog1));
    // smaller variant: no port g, port one handed to the converter
    general_purpose_port_block #(.DIR_C(MC), .DIR_D(MD), .DIR_E(ME), .DIR_F(MF),
        .DIR_G(MG), .HAS_PORT_G(1'b0), .PORT_ONE_ANALOG(1'b1)) dut2 (.clk(clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata2), .one_in(one_pin), .one_out(),
        .one_oe(one_oe2), .two_in(two_pin), .two_out(), .two_oe(), .c_in(c_pin),
        .c_out(), .c_oe(), .d_in(d_pin), .d_out(), .d_oe(), .e_in(e_pin), .e_out(),
        .e_oe(), .f_in(f_pin), .f_out(), .f_oe(), .g_in(g_pin), .g_out(), .g_oe(),
        .analog_select(analog2));
    pin_partner p1 (.ext(xv[1]), .out(one_out), .oe(one_oe), .pin(one_pin));
    pin_partner p2 (.ext(xv[2]), .out(two_out), .oe(two_oe), .pin(two_pin));
    pin_partner #(.W(2)) p3 (.ext(xv[3][1:0]), .out(c_out), .oe(c_oe), .pin(c_pin));
    pin_partner p4 (.ext(xv[4]), .out(d_out), .oe(d_oe), .pin(d_pin));
    pin_partner p5 (.ext(xv[5]), .out(e_out), .oe(e_oe), .pin(e_pin));
    pin_partner #(.W(3)) p6 (.ext(xv[6][2:0]), .out(f_out), .oe(f_oe), .pin(f_pin));
    pin_partner #(.W(2)) p7 (.ext(xv[7][1:0]), .out(g_out), .oe(g_oe), .pin(g_pin));

    // ---------------------------------------------------------------
    // model, bus tasks and comparison
    // ---------------------------------------------------------------
    // output mask per register index; programmable ports follow the direction bits
    function automatic int msk(input int a);
        case (a)
            1: return dir[0] ? 15 : 0;
            2: return dir[1] ? 15 : 0;
            3: return MC;
            4: return MD;
            5: return ME;
            6: return MF;
            7: return MG;
            default: return 0;
        endcase
    endfunction : msk
    // implemented bits per index; unmapped ones hold nothing
    function automatic int wid(input int a);
        case (a)
            1, 2, 4, 5: return 15;
            3, 7, 13: return 3;
            6: return 7;
            default: return 0;
        endcase
    endfunction : wid
    function automatic logic [3:0] exp_rd(input int a);
        if (a == 0) return 4'(sel);
        if (sel == 0) return 4'h0;
        if (a == 13) return 4'(dir);
        if (a < 1 || a > 7) return 4'h0;
        return 4'(((msk(a) & lat[a]) | (~msk(a) & xv[a])) & wid(a));
    endfunction : exp_rd
    function automatic logic [7:0] pout(input int a);
        case (a)
            3: return {2'h0, c_oe, 2'h0, c_out};
            4: return {d_oe, d_out};
            5: return {e_oe, e_out};
            6: return {1'h0, f_oe, 1'h0, f_out};
            default: return {2'h0, g_oe, 2'h0, g_out};
        endcase
    endfunction : pout
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one-cycle write; model follows once the taking edge has passed
    task automatic wr(input int a, input int d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 4'(a);
        reg_wdata <= 4'(d);
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
        if (a == 0) sel = d & 1;
        else if (sel != 0 && a == 13) dir = d & 3;
        else if (sel != 0) lat[a] = d & wid(a);
    endtask : wr
    // read data stand only in the cycle after the strobe, so look just past the edge
    task automatic rd(input int a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= 4'(a);
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
    endtask : rd
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // ---------------------------------------------------------------
    // clock, watchdog and test sequence
    // ---------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end
    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        foreach (xv[i]) xv[i] = 4'h0;
        foreach (lat[i]) lat[i] = 0;
        void'($urandom(32'hb166));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check({one_oe, two_oe}, 8'h0);
        rd(13);
        check(rdata, 4'h0);
        wr(0, 1);
        rd(13);
        check(rdata, exp_rd(13));
        $display("test reset done");
        // latch first while still input, as software must before turning around
        for (int p = 1; p <= 2; p++) begin
            @(posedge clk);
            xv[p] <= 4'($urandom);
            wr(p, $urandom);
        end
        check(two_out, 4'(lat[2]));
        check({one_oe, two_oe}, 8'h0);
        repeat (4) @(posedge clk);
        for (int p = 1; p <= 2; p++) begin
            rd(p);
            check(rdata, exp_rd(p));
        end
        $display("test input reads done");
        for (int dv = 0; dv < 4; dv++) begin
            wr(13, dv);
            @(posedge clk);
            #1;
            check(one_oe, {4{dir[0]}});
            check(two_oe, {4{dir[1]}});
            check(one_oe2, 4'h0);
            check(analog2, 1'b1);
            check(analog1, 1'b0);
            wr(1 + dv % 2, $urandom);
            check({one_pin, two_pin}, {exp_rd(1), exp_rd(2)});
            rd(13);
            check(rdata, exp_rd(13));
            for (int p = 1; p <= 2; p++) begin
                rd(p);
                check(rdata, exp_rd(p));
                check(rdata2, p == 1 ? 4'h0 : exp_rd(p));
            end
        end
        $display("test direction done");
        for (int n = 0; n < 20; n++) begin
            int a;
            a = 3 + n % 5;
            @(posedge clk);
            xv[a] <= 4'($urandom);
            wr(a, $urandom);
            check(pout(a), {4'(msk(a)), 4'(lat[a] & msk(a))});
            repeat (3) @(posedge clk);
            rd(a);
            check(rdata, exp_rd(a));
            check(rdata2, a == 7 ? 4'h0 : exp_rd(a));
        end
        $display("test fixed ports done");
        // reset again mid-run, with both ports driving and latches loaded
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        sel = 0;
        dir = 0;
        foreach (lat[i]) lat[i] = 0;
        check({one_oe, two_oe}, 8'h0);
        check(two_out, 4'h0);
        wr(0, 1);
        rd(13);
        check(rdata, exp_rd(13));
        $display("test mid reset done");
        wr(9, 15);
        rd(9);
        check(rdata, 4'h0);
        wr(0, 0);
        rd(1);
        check(rdata, 4'h0);
        $display("test table select done");
        tally_and_finish();
    end
endmodule : tb
